// ---- hdl/tick_timer_defs.svh ----
`ifndef TICK_TIMER_DEFS_SVH
`define TICK_TIMER_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define TT_CTRL_IDX 8'h39
`define TT_STAT_IDX 8'h3A
`define TT_MASK_IDX 8'h3B
`define TT_MODE_IDX 8'h3C
`define TT_CNT_IDX 8'h3D

// Control register fields.
`define TT_EN_BIT 3
`define TT_RATE_LSB 0
`define TT_CTRL_RESET 8'h00

// Status and mask fields.
`define TT_EV_TICK 0
`define TT_EV_STOP 1
`define TT_EV_MISUSE 2
`define TT_EV_RESET 3'h0

// Tap bit index for each rate code, code 0 in the low five bits.
// A tap of bit k falls once every 2^(k+1) source counts.
`define TT_GEAR_TAPS {5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h13, 5'h15}
`define TT_LOW_TAPS {5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0C, 5'h0E}
`define TT_SLOW_CODES 2

`define TT_GEAR_BITS 22
`define TT_LOW_BITS 15

`endif

// ---- hdl/tick_timer_pkg.sv ----
`include "tick_timer_defs.svh"

package tick_timer_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_SLOW,
    MODE_SLEEP1,
    MODE_STOP
  } op_mode_t;

  typedef struct packed {
    logic en;
    logic [2:0] rate;
  } ctrl_t;

  typedef struct packed {
    logic valid;
    logic from_low;
    logic [4:0] bit_idx;
  } tap_t;

  function automatic tap_t tap_decode(input op_mode_t m, input logic pre, input logic [2:0] rate);
    logic [39:0] gear;
    logic [39:0] low;
    tap_t t;
    gear = `TT_GEAR_TAPS;
    low = `TT_LOW_TAPS;
    t = '0;
    unique case (m)
      MODE_NORMAL, MODE_IDLE:
      begin
        t.from_low = pre;
        t.bit_idx = pre ? low[rate*5 +: 5] : gear[rate*5 +: 5];
        t.valid = !(pre && (rate == 3'h7));
      end
      MODE_SLOW, MODE_SLEEP1:
      begin
        t.from_low = 1'b1;
        t.bit_idx = low[rate*5 +: 5];
        t.valid = (rate < 3'(`TT_SLOW_CODES));
      end
      default:
      begin
        t = '0;
      end
    endcase
    return t;
  endfunction : tap_decode

endpackage : tick_timer_pkg

// ---- hdl/tick_divider_chain.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defs.svh"

module tick_divider_chain
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic low_frequency_clock,
  output logic [`TT_GEAR_BITS-1:0] gear_div,
  output logic [`TT_LOW_BITS-1:0] low_div
);

  logic lf_meta_q;
  logic lf_sync_q;
  logic lf_prev_q;

  // The low clock is brought onto the gear clock, which costs up to one cycle of jitter.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lf_meta_q <= 1'b0;
      lf_sync_q <= 1'b0;
      lf_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      lf_meta_q <= low_frequency_clock;
      lf_sync_q <= lf_meta_q;
      lf_prev_q <= lf_sync_q;
    end
  end

  // Both counters run free; nothing in the register file resets them.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gear_div <= '0;
      low_div <= '0;
    end
    else if (ce)
    begin
      gear_div <= gear_div + 1'b1;
      if (lf_sync_q && !lf_prev_q)
      begin
        low_div <= low_div + 1'b1;
      end
    end
  end

endmodule : tick_divider_chain

`default_nettype wire

// ---- hdl/tick_edge_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defs.svh"

module tick_edge_select
  import tick_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TT_GEAR_BITS-1:0] gear_div,
  input wire logic [`TT_LOW_BITS-1:0] low_div,
  input wire tap_t tap,
  output logic fall
);

  logic src_bit;
  logic src_prev_q;

  always_comb
  begin
    if (tap.from_low)
    begin
      src_bit = low_div[tap.bit_idx[3:0]];
    end
    else
    begin
      src_bit = gear_div[tap.bit_idx];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      src_prev_q <= src_bit;
    end
  end

  assign fall = src_prev_q && !src_bit && tap.valid;

endmodule : tick_edge_select

`default_nettype wire

// ---- hdl/time_base_tick_timer.sv ----
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defs.svh"

module time_base_tick_timer
  import tick_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] op_mode,
  input wire logic low_clock_prescale_select,
  input wire logic low_frequency_clock,
  output logic tick_interrupt_request,
  output logic irq
);

  ctrl_t ctrl_q;
  ctrl_t ctrl_d;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] stat_set;
  logic [2:0] stat_clr;
  logic [2:0] mask_q;
  logic [15:0] tick_count_q;
  op_mode_t mode;
  op_mode_t mode_prev_q;
  logic stop_entry;
  tap_t tap;
  logic [`TT_GEAR_BITS-1:0] gear_div;
  logic [`TT_LOW_BITS-1:0] low_div;
  logic src_fall;
  logic tick_fire;
  logic req_live;
  logic accept;
  logic wr_accept;
  logic rd_accept;
  logic lane0_wr;
  logic [31:0] rd_value;
  logic ctrl_hit;
  logic stat_hit;
  logic mask_hit;
  logic mode_hit;
  logic cnt_hit;
  logic ctrl_wr;
  logic mask_wr;
  logic stat_rd;
  logic rate_misuse;
  logic mode_misuse;

  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    return (addr[1:0] == 2'h0) && (addr[9:2] == idx);
  endfunction : reg_hit

  // Codes outside the enum act as STOP so the block stays quiet.
  always_comb
  begin
    unique case (op_mode)
      3'h0: mode = MODE_NORMAL;
      3'h1: mode = MODE_IDLE;
      3'h2: mode = MODE_SLOW;
      3'h3: mode = MODE_SLEEP1;
      default: mode = MODE_STOP;
    endcase
  end

  always_comb
  begin
    tap = tap_decode(mode, low_clock_prescale_select, ctrl_q.rate);
  end

  tick_divider_chain u_chain
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .low_frequency_clock(low_frequency_clock),
    .gear_div(gear_div),
    .low_div(low_div)
  );

  tick_edge_select u_edge
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .gear_div(gear_div),
    .low_div(low_div),
    .tap(tap),
    .fall(src_fall)
  );

  assign tick_fire = src_fall && ctrl_q.en;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_interrupt_request <= 1'b0;
    end
    else if (ce)
    begin
      tick_interrupt_request <= tick_fire;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_prev_q <= MODE_NORMAL;
    end
    else if (ce)
    begin
      mode_prev_q <= mode;
    end
  end

  assign stop_entry = (mode == MODE_STOP) && (mode_prev_q != MODE_STOP);

  // One wait state per access keeps read data and write timing fixed.
  assign req_live = avs_read || avs_write;
  assign accept = req_live && !avs_waitrequest;
  assign wr_accept = accept && avs_write;
  assign rd_accept = accept && avs_read;
  assign lane0_wr = wr_accept && avs_byteenable[0];

  // One decode per register keeps the write, clear and read paths in agreement.
  always_comb
  begin
    ctrl_hit = reg_hit(avs_address, `TT_CTRL_IDX);
    stat_hit = reg_hit(avs_address, `TT_STAT_IDX);
    mask_hit = reg_hit(avs_address, `TT_MASK_IDX);
    mode_hit = reg_hit(avs_address, `TT_MODE_IDX);
    cnt_hit = reg_hit(avs_address, `TT_CNT_IDX);
  end

  assign ctrl_wr = lane0_wr && ctrl_hit;
  assign mask_wr = lane0_wr && mask_hit;
  // Only an accepted read clears, so a stalled request cannot lose events twice.
  assign stat_rd = rd_accept && stat_hit;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (ce)
    begin
      avs_waitrequest <= !(req_live && avs_waitrequest);
    end
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrl_wr)
    begin
      ctrl_d.en = avs_writedata[`TT_EN_BIT];
      ctrl_d.rate = avs_writedata[`TT_RATE_LSB +: 3];
    end
    if (stop_entry)
    begin
      ctrl_d.en = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= ctrl_t'(4'(`TT_CTRL_RESET));
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mask_q <= `TT_EV_RESET;
    end
    else if (ce && mask_wr)
    begin
      mask_q <= avs_writedata[2:0];
    end
  end

  // A write that changes the rate while enabled is flagged, since the next tick then lands at an odd time.
  // misuse flag
  always_comb
  begin
    rate_misuse = ctrl_wr && ctrl_q.en && (avs_writedata[`TT_RATE_LSB +: 3] != ctrl_q.rate);
    mode_misuse = ctrl_q.en && (mode != mode_prev_q) && (mode != MODE_STOP);
  end

  always_comb
  begin
    stat_set = '0;
    stat_set[`TT_EV_TICK] = tick_fire;
    stat_set[`TT_EV_STOP] = stop_entry && ctrl_q.en;
    stat_set[`TT_EV_MISUSE] = rate_misuse || mode_misuse;
    stat_clr = stat_rd ? 3'h7 : 3'h0;
    // An event in the clearing cycle survives the read.
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= `TT_EV_RESET;
    end
    else if (ce)
    begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else if (ce)
    begin
      irq <= |(stat_d & mask_q);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_count_q <= 16'h0000;
    end
    else if (ce && tick_fire)
    begin
      tick_count_q <= tick_count_q + 16'h0001;
    end
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (ctrl_hit)
    begin
      rd_value[7:0] = {4'h0, ctrl_q.en, ctrl_q.rate};
    end
    else if (stat_hit)
    begin
      rd_value[2:0] = stat_q;
    end
    else if (mask_hit)
    begin
      rd_value[2:0] = mask_q;
    end
    else if (mode_hit)
    begin
      // Lets software see which source the current mode really uses and whether its tap is valid.
      rd_value[7:0] = {tap.valid, tap.from_low, low_clock_prescale_select, 2'h0, mode};
    end
    else if (cnt_hit)
    begin
      rd_value[15:0] = tick_count_q;
    end
  end

  // Read data is captured in the wait cycle and stands at the accepting edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (ce && avs_read && avs_waitrequest)
    begin
      avs_readdata <= rd_value;
    end
  end

endmodule : time_base_tick_timer

`default_nettype wire

// ---- bench/time_base_tick_timer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module time_base_tick_timer_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] op_mode,
  input wire logic tick_interrupt_request,
  input wire logic irq
);
  logic req;
  logic rd_ok;
  assign req = (avs_read || avs_write) && ce;
  assign rd_ok = avs_read && !avs_waitrequest;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_taken;
    req && avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_bus_one_wait: assert property (s_taken |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_bus_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without request");
  a_ctrl_upper_zero: assert property (rd_ok && avs_address == 10'h0E4 |-> avs_readdata[31:4] == '0)
    else $error("control upper bits not zero");
  a_unmapped_zero: assert property (rd_ok && (avs_address[1:0] != 2'h0 || avs_address[9:2] > 8'h3D
    || avs_address[9:2] < 8'h39) |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  a_tick_spacing: assert property (tick_interrupt_request |=> !tick_interrupt_request [*8])
    else $error("tick pulse too long or too close");
  a_stop_no_tick: assert property ((op_mode >= 3'h4) [*3] |-> !tick_interrupt_request)
    else $error("tick during stop");
  a_irq_clear: assert property ($fell(irq) |-> !$past(avs_waitrequest) || !$past(avs_waitrequest, 2))
    else $error("interrupt fell without bus access");
endmodule : time_base_tick_timer_properties
bind time_base_tick_timer time_base_tick_timer_properties u_props (.clk(clk), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .op_mode(op_mode), .tick_interrupt_request(tick_interrupt_request), .irq(irq));
`default_nettype wire

// ---- bench/time_base_tick_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module time_base_tick_timer_tb
  import tick_timer_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic pre = 1'b0;
  logic lfc = 1'b0;
  logic [9:0] a = '0;
  logic [31:0] wd = '0;
  logic [31:0] r;
  logic [31:0] rdat;
  logic [2:0] mode = 3'h0;
  logic [7:0] lf = 8'h36;
  logic wq;
  logic tick;
  logic irq;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  int t2;
  int nt = 0;
  logic ce = 1'b1;
  always #2.5 clk = ~clk;
  // The low clock toggles every cycle, so long low-clock codes stay short.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lfc <= ~lfc;
    if (tick === 1'b1)
    begin
      nt <= nt + 1;
    end
  end
  time_base_tick_timer u_dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(a), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wq), .op_mode(mode),
    .low_clock_prescale_select(pre), .low_frequency_clock(lfc), .tick_interrupt_request(tick), .irq(irq));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  function automatic int per(input logic [2:0] c, input logic lo);
    int g[8] = '{22, 20, 15, 13, 12, 11, 10, 8};
    int l[8] = '{15, 13, 8, 6, 5, 4, 3, 0};
    return lo ? (2 << l[c]) : (1 << g[c]);
  endfunction : per
  task automatic conclude();
    $display("checks=%0d fails=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic hang();
    fail_count++;
    conclude();
  endtask : hang
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    a <= {i, 2'h0};
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0)
      hang();
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic wtick(input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < lim);
    if (tick !== 1'b1)
      hang();
    t0 = cyc;
  endtask : wtick
  task automatic quiet(input int len);
    int k;
    k = 0;
    repeat (len)
    begin
      @(posedge clk);
      k += (tick === 1'b1);
    end
    chk(k, 0);
  endtask : quiet
  task automatic meas(input logic [2:0] c, input logic lo);
    acc(1'b1, 8'h39, {29'h0, c});
    acc(1'b1, 8'h39, {28'h0, 1'b1, c});
    wtick(per(c, lo) + 50);
    t1 = t0;
    wtick(per(c, lo) + 50);
    chk(t0 - t1, per(c, lo));
  endtask : meas
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 8'h39, '0);
    chk(r, '0);
    acc(1'b1, 8'h39, 32'h0000_00F7);
    acc(1'b0, 8'h39, '0);
    chk(r, 32'h0000_0007);
    acc(1'b0, 8'h40, '0);
    chk(r, '0);
    $display("register test done");
    meas(3'h7, 1'b0);
    repeat (3)
    begin
      lf = nxt(lf);
      meas({2'h3, lf[0]}, 1'b0);
    end
    t2 = t0;
    acc(1'b1, 8'h39, 32'h0000_0007);
    quiet(600);
    repeat (lf[3:0] + 5) @(posedge clk);
    acc(1'b1, 8'h39, 32'h0000_000F);
    t1 = cyc;
    wtick(300);
    chk((t0 - t1) <= 256, 1);
    chk((t0 - t2) % 256, 0);
    t1 = t0;
    wtick(300);
    chk((t0 - t1) % 256, 0);
    $display("gear test done");
    acc(1'b1, 8'h3B, 32'h0000_0001);
    acc(1'b0, 8'h3A, '0);
    wtick(300);
    chk(irq, 1'b1);
    acc(1'b0, 8'h3A, '0);
    chk(r[0], 1'b1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    acc(1'b1, 8'h3B, '0);
    wtick(300);
    chk(irq, 1'b0);
    $display("interrupt test done");
    repeat (2) @(posedge clk);
    ce <= 1'b0;
    quiet(300);
    ce <= 1'b1;
    $display("clock enable test done");
    acc(1'b1, 8'h39, '0);
    pre <= 1'b1;
    meas(3'h6, 1'b1);
    meas(3'h3, 1'b1);
    acc(1'b1, 8'h39, 32'h0000_0007);
    acc(1'b1, 8'h39, 32'h0000_000F);
    quiet(300);
    acc(1'b1, 8'h39, 32'h0000_0002);
    mode <= MODE_SLOW;
    acc(1'b1, 8'h39, 32'h0000_000A);
    quiet(600);
    meas(3'h1, 1'b1);
    mode <= MODE_STOP;
    quiet(40);
    acc(1'b0, 8'h39, '0);
    chk(r, 32'h0000_0001);
    acc(1'b0, 8'h3A, '0);
    chk(r, 32'h0000_0007);
    acc(1'b0, 8'h3A, '0);
    chk(r, '0);
    acc(1'b0, 8'h3C, '0);
    chk(r, 32'h0000_0024);
    acc(1'b0, 8'h3D, '0);
    chk(r, nt & 32'h0000_FFFF);
    $display("low clock test done");
    conclude();
  end
endmodule : time_base_tick_timer_tb
`default_nettype wire
